/* File: hdl/status_bank_map.svh */
// register offsets, field positions and reset values of the status bank
// assumes: included by its bare name by the two bank modules
//
// Overview of operation
// - bridge 2 fall time is a read-only 6-bit code in bits 13:8, 53.3 ns per step.
// - bridge 2 rise time is a read-only 6-bit code in bits 5:0, 53.3 ns per step.
// - bridge 3 fall time is a read-only 6-bit code in bits 13:8, 53.3 ns per step.
// - bridge 3 rise time is a read-only 6-bit code in bits 5:0, 53.3 ns per step.
// - unused bits of every status register in the bank read as zero.
// - time registers clear on power-on or soft reset and keep their fields on restart.
// - bus lock reads 1 only after an error-free frame and 0 from one cycle after filtering stops.
// - the wake pattern flag is set by a detected pattern and cleared by a host read.
// - the wake frame flag is set by a matching frame and cleared by a host read.
// - the quiet bit is 1 once the bus stayed idle past the limit during partial wake.
// - the active bit needs no system error, valid config and mode bit 2 set.
// - partial wake starts on a transceiver mode change, never into mode 100.
// - wake status clears on power-on or soft reset and keeps bits 6 to 2 on restart.
// - 32 frame errors stop partial wake, set the system error and enable plain wake.
`ifndef STATUS_BANK_MAP_SVH
`define STATUS_BANK_MAP_SVH

// register indices; byte address is four times the index
`define HB2_SLEW_IDX      8'h58
`define HB3_SLEW_IDX      8'h59
`define WAKE_STAT_IDX     8'h60
`define WAKE_CTRL_IDX     8'h70
`define WAKE_ERR_IDX      8'h71

`define FALL_MSB          13
`define FALL_LSB          8
`define RISE_MSB          5
`define RISE_LSB          0
`define SYNC_BIT          6
`define PATTERN_BIT       5
`define FRAME_BIT         4
`define QUIET_BIT         3
`define ACTIVE_BIT        2

`define MODE_MSB          2
`define MODE_LSB          0
`define CFG_VALID_BIT     3
`define SYS_ERR_BIT       0
`define PLAIN_WAKE_BIT    1
`define ERR_CNT_MSB       13
`define ERR_CNT_LSB       8

`define STATUS_RESET      16'h0000
`define MODE_RESET        3'h0
`define MODE_NO_PARTIAL   3'h4
`define ERR_LIMIT         6'h20
`define SLEW_STEP_PS      53300

`endif

/* File: hdl/status_bank_pkg.sv */
// types shared by the status bank modules
// assumes: compiled before the bank modules
`default_nettype none

package status_bank_pkg;

    typedef enum logic [1:0] {
        WAKE_IDLE   = 2'b01,
        WAKE_ACTIVE = 2'b10
    } wake_state_type;

    typedef logic [15:0] status_word_type;

endpackage : status_bank_pkg

`default_nettype wire

/* File: hdl/slew_capture.sv */
// one half-bridge rise/fall time register
// assumes: codes and strobe come from the measurement logic on clk_in
`include "status_bank_map.svh"
`default_nettype none

module slew_capture
    import status_bank_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       soft_reset_in,
    input  wire logic       capture_in,
    input  wire logic [5:0] rise_in,
    input  wire logic [5:0] fall_in,
    output status_word_type word_out
);

    logic [5:0] rise_q;
    logic [5:0] rise_d;
    logic [5:0] fall_q;
    logic [5:0] fall_d;

    always_comb begin
        rise_d = rise_q;
        fall_d = fall_q;
        if (soft_reset_in) begin
            rise_d = 6'h00;
            fall_d = 6'h00;
        end else if (capture_in) begin
            rise_d = rise_in;
            fall_d = fall_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rise_q <= 6'h00;
            fall_q <= 6'h00;
        end else begin
            rise_q <= rise_d;
            fall_q <= fall_d;
        end
    end

    // reserved bits are constant zero, so restart has nothing to clear
    always_comb begin
        word_out = `STATUS_RESET;
        word_out[`FALL_MSB:`FALL_LSB] = fall_q;
        word_out[`RISE_MSB:`RISE_LSB] = rise_q;
    end

endmodule : slew_capture

`default_nettype wire

/* File: hdl/status_readback_bank.sv */
// status readback bank: bridge slew times and partial-wake status
// assumes: event inputs are one-cycle pulses from logic on clk_in;
// sole AHB-Lite slave, so hready_in is its own hreadyout_out
`include "status_bank_map.svh"
`default_nettype none

module status_readback_bank
    import status_bank_pkg::*;
#(
    parameter int QUIET_LIMIT_CYCLES = 50000
)(
    input  wire logic        clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        soft_reset_in,
    input  wire logic        restart_in,
    input  wire logic        capture_b2_in,
    input  wire logic [5:0]  rise_time_b2_in,
    input  wire logic [5:0]  fall_time_b2_in,
    input  wire logic        capture_b3_in,
    input  wire logic [5:0]  rise_time_b3_in,
    input  wire logic [5:0]  fall_time_b3_in,
    input  wire logic        wake_pattern_in,
    input  wire logic        wake_frame_in,
    input  wire logic        frame_ok_in,
    input  wire logic        frame_error_in,
    input  wire logic        bus_idle_in,
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic             partial_wake_active_out,
    output logic             plain_wake_enable_out,
    output logic             wake_request_out
);

    localparam int QW = $clog2(QUIET_LIMIT_CYCLES + 1);
    localparam logic [QW-1:0] QUIET_LIMIT = QW'(QUIET_LIMIT_CYCLES);

    // true when a byte address selects the given register index
    function automatic logic hits(input logic [31:0] addr,
                                  input logic [7:0]  idx);
        hits = (addr[31:10] == 22'h00_0000) && (addr[9:2] == idx);
    endfunction : hits

    ////////////////////////////////////////////////////////////////////////
    // slew time registers

    status_word_type slew_word [2];

    slew_capture u_slew_b2 (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .soft_reset_in (soft_reset_in),
        .capture_in    (capture_b2_in),
        .rise_in       (rise_time_b2_in),
        .fall_in       (fall_time_b2_in),
        .word_out      (slew_word[0])
    );

    slew_capture u_slew_b3 (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_in),
        .soft_reset_in (soft_reset_in),
        .capture_in    (capture_b3_in),
        .rise_in       (rise_time_b3_in),
        .fall_in       (fall_time_b3_in),
        .word_out      (slew_word[1])
    );

    ////////////////////////////////////////////////////////////////////////
    // bus address phase

    logic addr_ok;
    logic rd_go;
    logic wr_go;
    logic stat_read;

    assign addr_ok   = hsel_in && htrans_in[1] && hready_in;
    assign rd_go     = addr_ok && !hwrite_in;
    assign wr_go     = addr_ok && hwrite_in;
    assign stat_read = rd_go && hits(haddr_in, `WAKE_STAT_IDX);

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    logic       wr_pend_q;
    logic       wr_pend_d;
    logic [7:0] wr_idx_q;
    logic [7:0] wr_idx_d;
    logic       ctrl_wr;
    logic       err_wr;

    always_comb begin
        wr_pend_d = wr_go;
        wr_idx_d  = wr_go ? haddr_in[9:2] : wr_idx_q;
        if (wr_go && haddr_in[31:10] != 22'h00_0000) begin
            wr_pend_d = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
        end
    end

    // only the control and error registers have a write path; status registers have none
    assign ctrl_wr = wr_pend_q && (wr_idx_q == `WAKE_CTRL_IDX);
    assign err_wr  = wr_pend_q && (wr_idx_q == `WAKE_ERR_IDX);

    ////////////////////////////////////////////////////////////////////////
    // control register: transceiver mode and config valid

    logic [2:0] mode_q;
    logic [2:0] mode_d;
    logic       cfg_valid_q;
    logic       cfg_valid_d;
    logic       mode_change;

    always_comb begin
        mode_d      = mode_q;
        cfg_valid_d = cfg_valid_q;
        if (soft_reset_in) begin
            mode_d      = `MODE_RESET;
            cfg_valid_d = 1'b0;
        end else if (ctrl_wr) begin
            mode_d      = hwdata_in[`MODE_MSB:`MODE_LSB];
            cfg_valid_d = hwdata_in[`CFG_VALID_BIT];
        end
    end

    assign mode_change = ctrl_wr && !soft_reset_in
                      && (hwdata_in[`MODE_MSB:`MODE_LSB] != mode_q);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode_q      <= `MODE_RESET;
            cfg_valid_q <= 1'b0;
        end else begin
            mode_q      <= mode_d;
            cfg_valid_q <= cfg_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // partial wake state, frame error counter and system error

    wake_state_type state_q;
    wake_state_type state_d;
    logic [5:0]     err_cnt_q;
    logic [5:0]     err_cnt_d;
    logic           sys_err_q;
    logic           sys_err_d;
    logic           plain_wake_q;
    logic           plain_wake_d;
    logic           active;
    logic           start_ok;
    logic           overflow;

    assign active   = (state_q == WAKE_ACTIVE);
    assign overflow = (err_cnt_d == `ERR_LIMIT);
    assign start_ok = mode_change && !sys_err_q && cfg_valid_d
                   && mode_d[2]
                   && (mode_d != `MODE_NO_PARTIAL);

    always_comb begin
        err_cnt_d = err_cnt_q;
        if (active && frame_error_in && err_cnt_q != `ERR_LIMIT) begin
            err_cnt_d = err_cnt_q + 6'h01;
        end else if (active && frame_ok_in && err_cnt_q != 6'h00) begin
            err_cnt_d = err_cnt_q - 6'h01;
        end
        if (soft_reset_in) begin
            err_cnt_d = 6'h00;
        end
    end

    always_comb begin
        state_d      = state_q;
        sys_err_d    = sys_err_q;
        plain_wake_d = plain_wake_q;
        // software may clear the error by writing one; overflow wins
        if (err_wr && hwdata_in[`SYS_ERR_BIT]) begin
            sys_err_d = 1'b0;
        end
        if (err_wr && hwdata_in[`PLAIN_WAKE_BIT]) begin
            plain_wake_d = 1'b0;
        end
        unique case (state_q)
            WAKE_IDLE: begin
                if (start_ok) begin
                    state_d = WAKE_ACTIVE;
                end
            end
            WAKE_ACTIVE: begin
                if (overflow) begin
                    state_d      = WAKE_IDLE;
                    sys_err_d    = 1'b1;
                    plain_wake_d = 1'b1;
                end else if (!cfg_valid_q || !mode_q[2]) begin
                    state_d = WAKE_IDLE;
                end
            end
            default: state_d = WAKE_IDLE;
        endcase
        if (soft_reset_in) begin
            state_d      = WAKE_IDLE;
            sys_err_d    = 1'b0;
            plain_wake_d = 1'b0;
        end
    end

    // restart leaves all of this state alone
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q      <= WAKE_IDLE;
            err_cnt_q    <= 6'h00;
            sys_err_q    <= 1'b0;
            plain_wake_q <= 1'b0;
        end else begin
            state_q      <= state_d;
            err_cnt_q    <= err_cnt_d;
            sys_err_q    <= sys_err_d;
            plain_wake_q <= plain_wake_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake status flags and bus silence timer

    logic          sync_q;
    logic          sync_d;
    logic          pattern_q;
    logic          pattern_d;
    logic          frame_q;
    logic          frame_d;
    logic          quiet_q;
    logic          quiet_d;
    logic [QW-1:0] quiet_cnt_q;
    logic [QW-1:0] quiet_cnt_d;

    always_comb begin
        sync_d      = sync_q;
        pattern_d   = pattern_q;
        frame_d     = frame_q;
        quiet_cnt_d = quiet_cnt_q;
        if (!active) begin
            sync_d = 1'b0;
        end else if (frame_ok_in) begin
            sync_d = 1'b1;
        end
        // clear first, then set: a same-cycle event survives the read
        if (stat_read) begin
            pattern_d = 1'b0;
            frame_d   = 1'b0;
        end
        if (wake_pattern_in) begin
            pattern_d = 1'b1;
        end
        if (wake_frame_in && active) begin
            frame_d = 1'b1;
        end
        if (!active || !bus_idle_in) begin
            quiet_cnt_d = '0;
        end else if (quiet_cnt_q != QUIET_LIMIT) begin
            quiet_cnt_d = quiet_cnt_q + QW'(1);
        end
        quiet_d = active && (quiet_cnt_d == QUIET_LIMIT);
        if (soft_reset_in) begin
            sync_d      = 1'b0;
            pattern_d   = 1'b0;
            frame_d     = 1'b0;
            quiet_d     = 1'b0;
            quiet_cnt_d = '0;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_q      <= 1'b0;
            pattern_q   <= 1'b0;
            frame_q     <= 1'b0;
            quiet_q     <= 1'b0;
            quiet_cnt_q <= '0;
        end else begin
            sync_q      <= sync_d;
            pattern_q   <= pattern_d;
            frame_q     <= frame_d;
            quiet_q     <= quiet_d;
            quiet_cnt_q <= quiet_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data: sampled in the address phase, before the flags clear

    status_word_type wake_word;
    logic [31:0]     hrdata_q;
    logic [31:0]     hrdata_d;
    logic            restart_unused;

    // reserved bits are constant zero, so restart has nothing to clear
    assign restart_unused = restart_in;

    always_comb begin
        wake_word = `STATUS_RESET;
        wake_word[`SYNC_BIT]    = sync_q;
        wake_word[`PATTERN_BIT] = pattern_q;
        wake_word[`FRAME_BIT]   = frame_q;
        wake_word[`QUIET_BIT]   = quiet_q;
        wake_word[`ACTIVE_BIT]  = active;
    end

    always_comb begin
        hrdata_d = hrdata_q;
        if (rd_go) begin
            hrdata_d = 32'h0000_0000;
            if (hits(haddr_in, `HB2_SLEW_IDX)) begin
                hrdata_d[15:0] = slew_word[0];
            end else if (hits(haddr_in, `HB3_SLEW_IDX)) begin
                hrdata_d[15:0] = slew_word[1];
            end else if (hits(haddr_in, `WAKE_STAT_IDX)) begin
                hrdata_d[15:0] = wake_word;
            end else if (hits(haddr_in, `WAKE_CTRL_IDX)) begin
                hrdata_d[`MODE_MSB:`MODE_LSB] = mode_q;
                hrdata_d[`CFG_VALID_BIT]      = cfg_valid_q;
            end else if (hits(haddr_in, `WAKE_ERR_IDX)) begin
                hrdata_d[`SYS_ERR_BIT]              = sys_err_q;
                hrdata_d[`PLAIN_WAKE_BIT]           = plain_wake_q;
                hrdata_d[`ERR_CNT_MSB:`ERR_CNT_LSB] = err_cnt_q;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            hrdata_q <= 32'h0000_0000;
        end else begin
            hrdata_q <= hrdata_d;
        end
    end

    assign hrdata_out              = hrdata_q;
    assign partial_wake_active_out = active;
    assign plain_wake_enable_out   = plain_wake_q;
    // pattern wakes only once plain wake is enabled after an overflow
    assign wake_request_out = (plain_wake_q && pattern_q)
                           || frame_q;

endmodule : status_readback_bank

`default_nettype wire

/* File: tb/status_bank_properties.sv */
// checker for the status readback bank: readback layout and wake outputs
// assumes: the bank is the sole AHB-Lite slave, one clock, async reset
`default_nettype none

module status_bank_checker
    import status_bank_pkg::*;
(
    input wire logic        clk_in,
    input wire logic        rst_n_in,
    input wire logic        soft_reset_in,
    input wire logic        wake_pattern_in,
    input wire logic        wake_frame_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        partial_wake_active_out,
    input wire logic        plain_wake_enable_out,
    input wire logic        wake_request_out
);
    logic        rd_d, rd_q, slew, stat;
    logic [31:0] addr_d, addr_q;

    always_comb begin
        rd_d   = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
        addr_d = rd_d ? haddr_in : addr_q;
        slew   = addr_q == 32'h0000_0160 || addr_q == 32'h0000_0164;
        stat   = addr_q == 32'h0000_0180;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q   <= 1'b0;
            addr_q <= 32'h0000_0000;
        end else begin
            rd_q   <= rd_d;
            addr_q <= addr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_start_needs_write: assert property (
        $rose(partial_wake_active_out) |-> $past(hwdata_in[3])
        && $past(hwdata_in[2]) && $past(hwdata_in[1:0]) != 2'b00)
        else $error("partial wake started without a qualifying write");
    a_overflow_stops: assert property (
        $rose(plain_wake_enable_out) |-> !partial_wake_active_out)
        else $error("plain wake enabled while partial wake active");
    a_slew_reserved: assert property (
        rd_q && slew |-> hrdata_out[31:14] == 18'h0_0000
        && hrdata_out[7:6] == 2'b00)
        else $error("slew register reserved bits not zero");
    a_stat_reserved: assert property (
        rd_q && stat |-> hrdata_out[31:7] == 25'h000_0000
        && hrdata_out[1:0] == 2'b00)
        else $error("wake status reserved bits not zero");
    a_active_bit: assert property (
        rd_q && stat |-> hrdata_out[2] == $past(partial_wake_active_out))
        else $error("active bit differs from active output");
    // two idle cycles so a lock bit still draining after the drop is allowed
    a_idle_no_lock: assert property (
        rd_q && stat && !$past(partial_wake_active_out)
        && !$past(partial_wake_active_out, 2)
        |-> hrdata_out[6] == 1'b0 && hrdata_out[3] == 1'b0)
        else $error("lock or quiet bit set while partial wake idle");
    a_soft_clear: assert property (
        soft_reset_in |=> !partial_wake_active_out
        && !plain_wake_enable_out && !wake_request_out)
        else $error("soft reset left wake outputs set");
    a_wake_cause: assert property (
        $rose(wake_request_out) |-> $past(wake_pattern_in)
        || $past(wake_frame_in) || $rose(plain_wake_enable_out))
        else $error("wake request rose without a cause");

    c_start: cover property ($rose(partial_wake_active_out));
    c_overflow: cover property ($rose(plain_wake_enable_out));
    c_pattern: cover property (rd_q && stat && hrdata_out[5]);
endmodule : status_bank_checker

bind status_readback_bank status_bank_checker chk (.clk_in, .rst_n_in,
    .soft_reset_in, .wake_pattern_in, .wake_frame_in, .hsel_in, .haddr_in,
    .htrans_in, .hwrite_in, .hwdata_in, .hready_in, .hrdata_out,
    .partial_wake_active_out, .plain_wake_enable_out, .wake_request_out);

`default_nettype wire

/* File: tb/ahb_host.sv */
// host model: single-word AHB-Lite master issuing one transfer at a time
// assumes: hready is the bank's hreadyout, signals change after rising edges
`default_nettype none

module ahb_host (
    input  wire logic        clk_in,
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    output logic             hsel_out,
    output logic [31:0]      haddr_out,
    output logic [1:0]       htrans_out,
    output logic             hwrite_out,
    output logic [2:0]       hsize_out,
    output logic [31:0]      hwdata_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        hsel_out   = 1'b0;
        haddr_out  = 32'h0000_0000;
        htrans_out = 2'b00;
        hwrite_out = 1'b0;
        hsize_out  = 3'b010;
        hwdata_out = 32'hA5A5_5A5A;
    end

    // wait states are allowed: both phases last until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] adr,
                        input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge clk_in);
        hsel_out   <= 1'b1;
        haddr_out  <= adr;
        htrans_out <= 2'b10;
        hwrite_out <= wr;
        hsize_out  <= 3'b010;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        hsel_out   <= 1'b0;
        htrans_out <= 2'b00;
        // a read data phase leaves stale write data toggled, never reused
        hwdata_out <= wr ? wdat : ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdat = hrdata_in;
    endtask : xfer
endmodule : ahb_host

`default_nettype wire

/* File: tb/status_readback_bank_test.sv */
// self-checking bench for the status readback bank
// assumes: host model drives the bus, events are one-cycle pulses
`default_nettype none

module status_readback_bank_test
    import status_bank_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int QUIET = 20;
    localparam int PAT = 0, FRM = 1, OK = 2, ERR = 3, RST = 4, SOFT = 5;
    localparam int CAP2 = 6, CAP3 = 7;
    localparam logic [31:0] STAT = 32'h0000_0180;

    logic        clk_in, rst_n_in, bus_idle, hsel, hwrite, hready;
    logic        active, plain, wake_req, hresp;
    logic [7:0]  ev;
    logic [5:0]  rise_b2, fall_b2, rise_b3, fall_b3;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    int          n_errors, cmp_count;

    status_readback_bank #(.QUIET_LIMIT_CYCLES(QUIET)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .soft_reset_in(ev[SOFT]),
        .restart_in(ev[RST]), .capture_b2_in(ev[CAP2]),
        .rise_time_b2_in(rise_b2), .fall_time_b2_in(fall_b2),
        .capture_b3_in(ev[CAP3]), .rise_time_b3_in(rise_b3),
        .fall_time_b3_in(fall_b3), .wake_pattern_in(ev[PAT]),
        .wake_frame_in(ev[FRM]), .frame_ok_in(ev[OK]),
        .frame_error_in(ev[ERR]), .bus_idle_in(bus_idle), .hsel_in(hsel),
        .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
        .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .partial_wake_active_out(active), .plain_wake_enable_out(plain),
        .wake_request_out(wake_req));

    ahb_host host (.clk_in(clk_in), .hready_in(hready), .hrdata_in(hrdata),
        .hsel_out(hsel), .haddr_out(haddr), .htrans_out(htrans),
        .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rd_chk(string what, logic [31:0] a, logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, rd);
        chk(what, exp, rd);
    endtask : rd_chk

    task automatic wr(logic [31:0] a, logic [31:0] d);
        host.xfer(1'b1, a, d, rd);
    endtask : wr

    task automatic pulse(int b);
        @(posedge clk_in);
        ev[b] <= 1'b1;
        @(posedge clk_in);
        ev[b] <= 1'b0;
    endtask : pulse

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up

    ////////////////////////////////////////////////////////////////////////
    task automatic t_slew;
        rd_chk("hb2 reset", 32'h0000_0160, 32'h0000_0000);
        rd_chk("stat reset", STAT, 32'h0000_0000);
        wr(32'h0000_0200, 32'hFFFF_FFFF);
        rd_chk("unmapped", 32'h0000_0200, 32'h0000_0000);
        chk("okay resp", 32'h0000_0000, 32'(hresp));
        rise_b2 <= 6'h3F;
        fall_b2 <= 6'h2A;
        rise_b3 <= 6'h01;
        fall_b3 <= 6'h3F;
        pulse(CAP2);
        pulse(CAP3);
        rise_b2 <= 6'h15;
        rise_b3 <= 6'h15;
        rd_chk("hb2 codes", 32'h0000_0160, 32'h0000_2A3F);
        rd_chk("hb3 codes", 32'h0000_0164, 32'h0000_3F01);
        wr(32'h0000_0160, 32'hFFFF_FFFF);
        rd_chk("hb2 write", 32'h0000_0160, 32'h0000_2A3F);
        pulse(RST);
        rd_chk("hb3 restart", 32'h0000_0164, 32'h0000_3F01);
        pulse(SOFT);
        rd_chk("hb3 soft", 32'h0000_0164, 32'h0000_0000);
        $display("test slew done");
    endtask : t_slew

    task automatic t_flags;
        pulse(PAT);
        rd_chk("pattern set", STAT, 32'h0000_0020);
        rd_chk("pattern read", STAT, 32'h0000_0000);
        // event lands on the very edge that takes the clearing read
        fork
            host.xfer(1'b0, STAT, 32'h0000_0000, rd);
            pulse(PAT);
        join
        chk("race old", 32'h0000_0000, rd);
        rd_chk("race kept", STAT, 32'h0000_0020);
        $display("test flags done");
    endtask : t_flags

    task automatic t_partial;
        wr(32'h0000_01C0, 32'h0000_000C);
        #1 chk("mode 4", 32'h0000_0000, 32'(active));
        wr(32'h0000_01C0, 32'h0000_0006);
        #1 chk("no config", 32'h0000_0000, 32'(active));
        wr(32'h0000_01C0, 32'h0000_000D);
        #1 chk("start", 32'h0000_0001, 32'(active));
        rd_chk("active bit", STAT, 32'h0000_0004);
        pulse(OK);
        rd_chk("lock", STAT, 32'h0000_0044);
        pulse(FRM);
        #1 chk("frame wake", 32'h0000_0001, 32'(wake_req));
        rd_chk("frame set", STAT, 32'h0000_0054);
        rd_chk("frame read", STAT, 32'h0000_0044);
        bus_idle <= 1'b1;
        repeat (QUIET + 5) @(posedge clk_in);
        rd_chk("quiet", STAT, 32'h0000_004C);
        pulse(RST);
        rd_chk("restart", STAT, 32'h0000_004C);
        wr(STAT, 32'hFFFF_FFFF);
        rd_chk("stat write", STAT, 32'h0000_004C);
        bus_idle <= 1'b0;
        repeat (2) @(posedge clk_in);
        rd_chk("quiet gone", STAT, 32'h0000_0044);
        $display("test partial done");
    endtask : t_partial

    task automatic t_overflow;
        repeat (31) pulse(ERR);
        #1 chk("31 errors", 32'h0000_0001, 32'(active));
        pulse(ERR);
        #1 chk("stopped", 32'h0000_0000, 32'(active));
        chk("plain wake", 32'h0000_0001, 32'(plain));
        rd_chk("error reg", 32'h0000_01C4, 32'h0000_2003);
        rd_chk("lock gone", STAT, 32'h0000_0000);
        pulse(PAT);
        #1 chk("pattern wake", 32'h0000_0001, 32'(wake_req));
        $display("test overflow done");
    endtask : t_overflow

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    initial begin
        repeat (5000) @(posedge clk_in);
        n_errors++;
        $display("timeout waiting for the bank");
        wrap_up();
    end

    initial begin
        rst_n_in  = 1'b0;
        ev        = 8'h00;
        bus_idle  = 1'b0;
        rise_b2   = 6'h00;
        fall_b2   = 6'h00;
        rise_b3   = 6'h00;
        fall_b3   = 6'h00;
        n_errors  = 0;
        cmp_count = 0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        t_slew();
        t_flags();
        t_partial();
        t_overflow();
        wrap_up();
    end
endmodule : status_readback_bank_test

`default_nettype wire
